// File: shared/ilc_pkg.sv
package ilc_pkg;

  // ---------------------------------------------------------------
  // bus and word sizes
  // ---------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int LOG_ADDR_W = 9;
  localparam int COUNT_W = 7;
  localparam int SLOT_W = 5;

  // ---------------------------------------------------------------
  // register word indices on the avalon bus
  // ---------------------------------------------------------------
  localparam logic [5:0] HW_PEND_OFFSET = 6'h06;
  localparam logic [5:0] BC_PEND_OFFSET = 6'h07;
  localparam logic [5:0] RT_PEND_OFFSET = 6'h09;
  localparam logic [5:0] COUNT_PTR_OFFSET = 6'h0A;
  localparam logic [5:0] HW_EN_OFFSET = 6'h0F;
  localparam logic [5:0] HW_OE_OFFSET = 6'h13;
  localparam logic [5:0] BC_EN_OFFSET = 6'h20;
  localparam logic [5:0] BC_OE_OFFSET = 6'h21;
  localparam logic [5:0] RT_EN_OFFSET = 6'h22;
  localparam logic [5:0] RT_OE_OFFSET = 6'h23;
  localparam logic [5:0] CONTROL_OFFSET = 6'h24;

  // ---------------------------------------------------------------
  // field layout
  // ---------------------------------------------------------------
  localparam int CONTROL_BC_ENABLE_BIT = 0;
  localparam int CONTROL_RT_ENABLE_BIT = 1;
  localparam int CONTROL_SOFT_RESET_BIT = 2;
  localparam int CONTROLLER_NONZERO_BIT = 0;
  localparam int TERMINAL_NONZERO_BIT = 2;
  localparam int COUNT_LSB = 9;
  localparam logic [15:0] HW_FLAG_MASK = 16'hFFF8;
  localparam logic [2:0] LOG_TOP_BITS = 3'h6;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] HW_EN_RESET = 16'hE000;
  localparam logic [15:0] HW_OE_RESET = 16'h0000;
  localparam logic [15:0] HW_LOC_WORD = 16'h0000;
  localparam logic [8:0] LOG_PTR_FIRST = 9'h180;
  localparam logic [8:0] LOG_PTR_LAST = 9'h1BE;
  localparam logic [6:0] COUNT_MAX = 7'h7F;
  localparam logic [15:0] COUNT_PTR_RESET = 16'h0180;

  // ---------------------------------------------------------------
  // log writer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0]
  {
    ILC_WR_IDLE = 3'b001,
    ILC_WR_ID = 3'b010,
    ILC_WR_LOC = 3'b100
  } ilc_wr_state_t;

endpackage

// File: src/ilc_log_writer.sv
`timescale 1ns/100ps
`default_nettype none
module ilc_log_writer
(
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [ilc_pkg::LOG_ADDR_W-1:0] start_ptr,
  input wire logic [ilc_pkg::DATA_W-1:0] start_id,
  input wire logic [ilc_pkg::DATA_W-1:0] start_loc,
  output logic busy,
  output logic done,
  output logic ram_we,
  output logic [ilc_pkg::LOG_ADDR_W-1:0] ram_addr,
  output logic [ilc_pkg::DATA_W-1:0] ram_wdata
);
  import ilc_pkg::*;

  ilc_wr_state_t state;
  logic [DATA_W-1:0] loc_hold;

  assign busy = (state != ILC_WR_IDLE);

  // ---------------------------------------------------------------
  // two-word entry sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state <= ILC_WR_IDLE;
      ram_we <= 1'b0;
      ram_addr <= LOG_PTR_FIRST;
      ram_wdata <= 16'h0000;
      loc_hold <= 16'h0000;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (state)
        ILC_WR_IDLE:
        begin
          if (start)
          begin
            state <= ILC_WR_ID;
            ram_we <= 1'b1;
            ram_addr <= start_ptr;
            ram_wdata <= start_id;
            loc_hold <= start_loc;
          end
        end
        ILC_WR_ID:
        begin
          state <= ILC_WR_LOC;
          ram_addr <= ram_addr + 9'h001;
          ram_wdata <= loc_hold;
        end
        ILC_WR_LOC:
        begin
          state <= ILC_WR_IDLE;
          ram_we <= 1'b0;
          done <= 1'b1;
        end
        default:
        begin
          state <= ILC_WR_IDLE;
          ram_we <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  log_pair_a: assert property (@(posedge clk) disable iff (reset)
    (start && !busy) |=> (ram_we && ram_addr == $past(start_ptr)) ##1
    (ram_we && ram_addr == $past(start_ptr, 2) + 9'h001) ##1 done)
    else $error("log entry not written as a word pair");

endmodule
`default_nettype wire

// File: src/ilc_interrupt_manager.sv
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none
module ilc_interrupt_manager
#(
  parameter int DATA_WIDTH = ilc_pkg::DATA_W
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [ilc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [ilc_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [1:0] avs_byteenable,
  output logic [ilc_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [ilc_pkg::DATA_W-1:0] hw_event,
  input wire logic [ilc_pkg::DATA_W-1:0] bc_event,
  input wire logic [ilc_pkg::DATA_W-1:0] bc_event_location,
  input wire logic [ilc_pkg::DATA_W-1:0] rt_event,
  input wire logic [ilc_pkg::DATA_W-1:0] rt_event_location,
  output logic irq_n,
  output logic terminal_soft_reset,
  output logic log_we,
  output logic [ilc_pkg::LOG_ADDR_W-1:0] log_addr,
  output logic [ilc_pkg::DATA_W-1:0] log_data
);
  import ilc_pkg::*;

  if (DATA_WIDTH != DATA_W)
  begin : width_check
    $error("data width must be 16");
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] merge_bytes(input logic [15:0] old, input logic [15:0] wd,
                                              input logic [1:0] be);
    merge_bytes = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  function automatic logic [6:0] sat_inc(input logic [6:0] c);
    sat_inc = (c == COUNT_MAX) ? COUNT_MAX : c + 7'h01;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [15:0] hw_en, hw_oe, bc_en, bc_oe, rt_en, rt_oe;
  logic bc_active, rt_active;
  logic [15:0] hw_flags, bc_pend, rt_pend;
  logic [15:0] hw_q, bc_q, rt_q, bc_loc_q, rt_loc_q;
  logic [6:0] count;
  logic [4:0] slot;
  logic log_start;
  logic [15:0] log_id, log_loc;
  logic writer_busy, log_done;
  logic [15:0] hw_hits, bc_hits, rt_hits, hw_view, next_readdata;
  logic [8:0] log_ptr;
  logic [6:0] count_base;
  logic req, take, rd_take, wr_take, can_start, start_hw, start_bc, start_rt;
  logic clr_hw, clr_bc, clr_rt, clr_count;

  // ---------------------------------------------------------------
  // event qualification
  // ---------------------------------------------------------------
  assign hw_hits = hw_event & hw_en & HW_FLAG_MASK;
  assign bc_hits = bc_event & bc_en & {16{bc_active}};
  assign rt_hits = rt_event & rt_en & {16{rt_active}};
  assign log_ptr = {LOG_TOP_BITS, slot, 1'b0};
  assign hw_view = hw_flags | {13'h0000, |rt_pend, 1'b0, |bc_pend};

  // ---------------------------------------------------------------
  // avalon access
  // ---------------------------------------------------------------
  assign req = avs_read || avs_write;
  assign take = req && !avs_waitrequest;
  assign rd_take = take && avs_read;
  assign wr_take = take && avs_write;
  assign clr_hw = rd_take && avs_address == HW_PEND_OFFSET;
  assign clr_bc = rd_take && avs_address == BC_PEND_OFFSET;
  assign clr_rt = rd_take && avs_address == RT_PEND_OFFSET;
  assign clr_count = rd_take && avs_address == COUNT_PTR_OFFSET;

  always_comb
  begin
    case (avs_address)
      HW_PEND_OFFSET: next_readdata = hw_view;
      BC_PEND_OFFSET: next_readdata = bc_pend;
      RT_PEND_OFFSET: next_readdata = rt_pend;
      COUNT_PTR_OFFSET: next_readdata = {count, log_ptr};
      HW_EN_OFFSET: next_readdata = hw_en;
      HW_OE_OFFSET: next_readdata = hw_oe;
      BC_EN_OFFSET: next_readdata = bc_en;
      BC_OE_OFFSET: next_readdata = bc_oe;
      RT_EN_OFFSET: next_readdata = rt_en;
      RT_OE_OFFSET: next_readdata = rt_oe;
      CONTROL_OFFSET: next_readdata = {14'h0000, rt_active, bc_active};
      default: next_readdata = 16'h0000;
    endcase
  end

  // one wait state; data is frozen in the wait cycle and cleared against it
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 16'h0000;
    end
    else
    begin
      avs_waitrequest <= !(req && avs_waitrequest);
      if (avs_read && avs_waitrequest)
      begin
        avs_readdata <= next_readdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // writable registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      hw_en <= HW_EN_RESET;
      hw_oe <= HW_OE_RESET;
      bc_en <= 16'h0000;
      bc_oe <= 16'h0000;
      rt_en <= 16'h0000;
      rt_oe <= 16'h0000;
      bc_active <= 1'b0;
      rt_active <= 1'b0;
      terminal_soft_reset <= 1'b0;
    end
    else
    begin
      terminal_soft_reset <= 1'b0;
      if (wr_take)
      begin
        case (avs_address)
          HW_EN_OFFSET: hw_en <= merge_bytes(hw_en, avs_writedata, avs_byteenable);
          HW_OE_OFFSET: hw_oe <= merge_bytes(hw_oe, avs_writedata, avs_byteenable);
          BC_EN_OFFSET: bc_en <= merge_bytes(bc_en, avs_writedata, avs_byteenable);
          BC_OE_OFFSET: bc_oe <= merge_bytes(bc_oe, avs_writedata, avs_byteenable);
          RT_EN_OFFSET: rt_en <= merge_bytes(rt_en, avs_writedata, avs_byteenable);
          RT_OE_OFFSET: rt_oe <= merge_bytes(rt_oe, avs_writedata, avs_byteenable);
          CONTROL_OFFSET:
          begin
            if (avs_byteenable[0])
            begin
              bc_active <= avs_writedata[CONTROL_BC_ENABLE_BIT];
              rt_active <= avs_writedata[CONTROL_RT_ENABLE_BIT];
              terminal_soft_reset <= avs_writedata[CONTROL_SOFT_RESET_BIT];
            end
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // pending registers, set wins over the read clear
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      hw_flags <= 16'h0000;
      bc_pend <= 16'h0000;
      rt_pend <= 16'h0000;
    end
    else
    begin
      hw_flags <= ((clr_hw ? hw_flags & ~avs_readdata : hw_flags) | hw_hits) & HW_FLAG_MASK;
      bc_pend <= (clr_bc ? bc_pend & ~avs_readdata : bc_pend) | bc_hits;
      rt_pend <= ((clr_rt || terminal_soft_reset) ? rt_pend & ~avs_readdata & {16{!terminal_soft_reset}}
                  : rt_pend) | rt_hits;
    end
  end

  // ---------------------------------------------------------------
  // request output
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      irq_n <= 1'b1;
    end
    else
    begin
      irq_n <= !(|(hw_flags & hw_oe) || |(bc_pend & bc_oe) || |(rt_pend & rt_oe));
    end
  end

  // ---------------------------------------------------------------
  // log entry queue, one merged entry per source
  // ---------------------------------------------------------------
  assign can_start = !writer_busy && !log_start && !log_done;
  assign start_hw = can_start && |hw_q;
  assign start_bc = can_start && !(|hw_q) && |bc_q;
  assign start_rt = can_start && !(|hw_q) && !(|bc_q) && |rt_q;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      hw_q <= 16'h0000;
      bc_q <= 16'h0000;
      rt_q <= 16'h0000;
      bc_loc_q <= 16'h0000;
      rt_loc_q <= 16'h0000;
      log_start <= 1'b0;
      log_id <= 16'h0000;
      log_loc <= 16'h0000;
    end
    else
    begin
      hw_q <= (start_hw ? 16'h0000 : hw_q) | hw_hits;
      bc_q <= (start_bc ? 16'h0000 : bc_q) | bc_hits;
      rt_q <= (start_rt ? 16'h0000 : rt_q) | rt_hits;
      if (|bc_hits)
      begin
        bc_loc_q <= bc_event_location;
      end
      if (|rt_hits)
      begin
        rt_loc_q <= rt_event_location;
      end
      log_start <= start_hw || start_bc || start_rt;
      if (start_hw)
      begin
        log_id <= hw_q;
        log_loc <= HW_LOC_WORD;
      end
      else if (start_bc)
      begin
        log_id <= bc_q;
        log_loc <= bc_loc_q;
      end
      else if (start_rt)
      begin
        log_id <= rt_q;
        log_loc <= rt_loc_q;
      end
    end
  end

  ilc_log_writer writer
  (
    .clk(clk),
    .reset(reset),
    .start(log_start),
    .start_ptr(log_ptr),
    .start_id(log_id),
    .start_loc(log_loc),
    .busy(writer_busy),
    .done(log_done),
    .ram_we(log_we),
    .ram_addr(log_addr),
    .ram_wdata(log_data)
  );

  // ---------------------------------------------------------------
  // count and log pointer; soft reset does not reach here
  // ---------------------------------------------------------------
  assign count_base = clr_count ? count - avs_readdata[15:COUNT_LSB] : count;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      count <= COUNT_PTR_RESET[15:COUNT_LSB];
      slot <= COUNT_PTR_RESET[5:1];
    end
    else
    begin
      count <= log_done ? sat_inc(count_base) : count_base;
      if (log_done)
      begin
        slot <= slot + 5'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  disabled_ignored_a: assert property (@(posedge clk) disable iff (reset)
    ((hw_flags & ~$past(hw_flags)) & ~$past(hw_hits)) == 16'h0000)
    else $error("hardware flag set without an enabled event");

  pending_set_a: assert property (@(posedge clk) disable iff (reset)
    (|hw_hits) |=> ((hw_flags & $past(hw_hits)) == $past(hw_hits)))
    else $error("enabled hardware event did not set its flag");

  read_clears_a: assert property (@(posedge clk) disable iff (reset)
    (clr_hw && hw_hits == 16'h0000) |=> ((hw_flags & $past(avs_readdata)) == 16'h0000))
    else $error("read pending flags not cleared");

  irq_raise_a: assert property (@(posedge clk) disable iff (reset)
    (|(hw_hits & hw_oe)) |-> ##2 !irq_n)
    else $error("output enabled event did not raise request");

  irq_idle_a: assert property (@(posedge clk) disable iff (reset)
    (hw_flags == 16'h0000 && bc_pend == 16'h0000 && rt_pend == 16'h0000)[*2] |-> irq_n)
    else $error("request active with nothing pending");

  summary_bits_a: assert property (@(posedge clk) disable iff (reset)
    (avs_read && avs_waitrequest && avs_address == HW_PEND_OFFSET) |=>
    avs_readdata[2:0] == {$past(rt_pend != 16'h0000), 1'b0, $past(bc_pend != 16'h0000)})
    else $error("summary bits disagree with pending registers");

  count_sat_a: assert property (@(posedge clk) disable iff (reset)
    (count == COUNT_MAX && !clr_count) |=> count == COUNT_MAX)
    else $error("count left saturation");

  count_step_a: assert property (@(posedge clk) disable iff (reset)
    (log_done && !clr_count && count < COUNT_MAX) |=> count == $past(count) + 7'h01)
    else $error("count did not advance on a logged entry");

  pointer_range_a: assert property (@(posedge clk) disable iff (reset)
    log_we |-> (log_addr[8:6] == LOG_TOP_BITS && log_addr[0] == $past(log_we)))
    else $error("log address out of range or odd at entry start");

  pointer_wrap_a: assert property (@(posedge clk) disable iff (reset)
    (log_done && log_ptr == LOG_PTR_LAST) |=> log_ptr == LOG_PTR_FIRST)
    else $error("log pointer did not wrap");

  soft_keep_a: assert property (@(posedge clk) disable iff (reset)
    (terminal_soft_reset && !log_done && !clr_count) |=> $stable(count) && $stable(slot))
    else $error("soft reset disturbed count register");

  hw_zero_loc_a: assert property (@(posedge clk) disable iff (reset)
    start_hw |=> ##2 (log_we && log_data == HW_LOC_WORD))
    else $error("hardware entry with nonzero location word");

  wrap_seen_c: cover property (@(posedge clk) disable iff (reset) log_done && log_ptr == LOG_PTR_LAST);
  irq_seen_c: cover property (@(posedge clk) disable iff (reset) $fell(irq_n));
  count_full_c: cover property (@(posedge clk) disable iff (reset) count == COUNT_MAX);
  two_sources_c: cover property (@(posedge clk) disable iff (reset) |hw_hits && |bc_hits);

endmodule
`default_nettype wire

// File: testbench/ilc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module ilc_host_model
(
  input wire logic clk,
  output logic [ilc_pkg::ADDR_W-1:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [ilc_pkg::DATA_W-1:0] avs_writedata,
  output logic [1:0] avs_byteenable,
  input wire logic [ilc_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic log_we,
  input wire logic [ilc_pkg::LOG_ADDR_W-1:0] log_addr,
  input wire logic [ilc_pkg::DATA_W-1:0] log_data
);
  import ilc_pkg::*;
  // ---------------------------------------------------------------
  // log ram and bus master
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] log_ram [0:511];
  logic [DATA_W-1:0] kept_hw_pending;

  initial
  begin
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 16'h0000;
    avs_byteenable = 2'h3;
    kept_hw_pending = 16'h0000;
  end

  always @(posedge clk)
  begin
    if (log_we)
      log_ram[log_addr] <= log_data;
  end

  task automatic access(input logic wr, input logic [5:0] a, input logic [15:0] wd, output logic [15:0] rd);
    @(posedge clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= wd;
    do
    begin
      @(posedge clk);
    end
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    // summaries kept since the read clears the register
    if (!wr && a == HW_PEND_OFFSET && rd[2:0] != 3'h0) kept_hw_pending = rd;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= ~wd;
  endtask
endmodule
`default_nettype wire

// File: testbench/tb_interrupt_manager_log_counter.sv
`timescale 1ns/100ps
`default_nettype none
module tb_interrupt_manager_log_counter;
  import ilc_pkg::*;
  typedef struct packed {logic [15:0] en; logic [15:0] oe; logic [15:0] ev; logic [15:0] pend; logic irq_n;} ilc_row_t;
  logic clk, reset, avs_read, avs_write, avs_waitrequest, irq_n, soft_rst, log_we;
  logic [5:0] avs_address;
  logic [1:0] avs_byteenable;
  logic [15:0] avs_writedata, avs_readdata, hw_event, bc_event, rt_event, ev_loc, log_data, rdv;
  logic [8:0] log_addr, exp_ptr;
  logic [6:0] exp_cnt;
  int fails, cmp_count;
  ilc_row_t rows [5] = '{'{16'h0000, 16'hFFFF, 16'h8000, 16'h0000, 1'b1}, '{16'h8000, 16'h0000, 16'h8000, 16'h8000, 1'b1},
    '{16'h4000, 16'h4000, 16'h4000, 16'h4000, 1'b0}, '{16'h1808, 16'h0008, 16'h1808, 16'h1808, 1'b0},
    '{16'hFFFF, 16'hFFFF, 16'h0007, 16'h0000, 1'b1}};

  ilc_interrupt_manager ilc_interrupt_manager_inst (.clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .hw_event(hw_event), .bc_event(bc_event),
    .bc_event_location(ev_loc), .rt_event(rt_event), .rt_event_location(ev_loc), .irq_n(irq_n),
    .terminal_soft_reset(soft_rst), .log_we(log_we), .log_addr(log_addr), .log_data(log_data));
  ilc_host_model ilc_host_model_inst (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .log_we(log_we), .log_addr(log_addr),
    .log_data(log_data));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] exp);
    ilc_host_model_inst.access(1'b0, a, 16'h0000, rdv);
    check(rdv, exp);
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    ilc_host_model_inst.access(1'b1, a, d, rdv);
  endtask
  task automatic pulse(input logic [15:0] h, input logic [15:0] b, input logic [15:0] r, input logic [15:0] loc);
    @(posedge clk);
    hw_event <= h;
    bc_event <= b;
    rt_event <= r;
    ev_loc <= loc;
    @(posedge clk);
    hw_event <= 16'h0000;
    bc_event <= 16'h0000;
    rt_event <= 16'h0000;
    ev_loc <= ~loc;
    repeat (8) @(posedge clk);
  endtask
  task automatic logged(input logic [15:0] id, input logic [15:0] loc);
    check(ilc_host_model_inst.log_ram[exp_ptr], id);
    check(ilc_host_model_inst.log_ram[exp_ptr + 9'h001], loc);
    exp_ptr = (exp_ptr == 9'h1BE) ? 9'h180 : exp_ptr + 9'h002;
    exp_cnt = (exp_cnt == 7'h7F) ? 7'h7F : exp_cnt + 7'h01;
  endtask
  task automatic end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, fails);
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // clock, watchdog and tests
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    finish_test();
  end
  initial
  begin
    fails = 0;
    cmp_count = 0;
    reset = 1'b1;
    hw_event = 16'h0000;
    bc_event = 16'h0000;
    rt_event = 16'h0000;
    ev_loc = 16'h0000;
    exp_ptr = 9'h180;
    exp_cnt = 7'h00;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    check({15'h0, irq_n}, 16'h0001);
    rd(HW_EN_OFFSET, 16'hE000);
    rd(HW_OE_OFFSET, 16'h0000);
    rd(COUNT_PTR_OFFSET, 16'h0180);
    end_test("reset");
    foreach (rows[i])
    begin
      wr(HW_EN_OFFSET, rows[i].en);
      wr(HW_OE_OFFSET, rows[i].oe);
      pulse(rows[i].ev, 16'h0000, 16'h0000, 16'h5A5A);
      check({15'h0, irq_n}, {15'h0, rows[i].irq_n});
      rd(HW_PEND_OFFSET, rows[i].pend);
      rd(HW_PEND_OFFSET, 16'h0000);
      check({15'h0, irq_n}, 16'h0001);
      if (rows[i].pend != 16'h0000)
        logged(rows[i].pend, 16'h0000);
    end
    rd(COUNT_PTR_OFFSET, {exp_cnt, exp_ptr});
    exp_cnt = 7'h00;
    end_test("table");
    wr(HW_EN_OFFSET, 16'h0000);
    pulse(16'h2000, 16'h0000, 16'h0000, 16'h0000);
    wr(HW_EN_OFFSET, 16'h2000);
    repeat (8) @(posedge clk);
    rd(HW_PEND_OFFSET, 16'h0000);
    end_test("late enable");
    wr(BC_EN_OFFSET, 16'hFFFF);
    wr(RT_EN_OFFSET, 16'hFFFF);
    pulse(16'h0000, 16'h0001, 16'h0000, 16'h1111);
    rd(HW_PEND_OFFSET, 16'h0000);
    wr(CONTROL_OFFSET, 16'h0003);
    pulse(16'h0000, 16'h0004, 16'h0000, 16'h1234);
    logged(16'h0004, 16'h1234);
    rd(HW_PEND_OFFSET, 16'h0001);
    pulse(16'h0000, 16'h0000, 16'h0010, 16'h4321);
    logged(16'h0010, 16'h4321);
    rd(HW_PEND_OFFSET, 16'h0005);
    check(ilc_host_model_inst.kept_hw_pending, 16'h0005);
    rd(BC_PEND_OFFSET, 16'h0004);
    rd(RT_PEND_OFFSET, 16'h0010);
    rd(HW_PEND_OFFSET, 16'h0000);
    wr(COUNT_PTR_OFFSET, 16'hFFFF);
    wr(CONTROL_OFFSET, 16'h0004);
    @(posedge clk);
    check({15'h0, soft_rst}, 16'h0001);
    rd(COUNT_PTR_OFFSET, {exp_cnt, exp_ptr});
    rd(6'h3F, 16'h0000);
    exp_cnt = 7'h00;
    end_test("terminals");
    wr(HW_EN_OFFSET, 16'h8000);
    repeat (130)
    begin
      pulse(16'h8000, 16'h0000, 16'h0000, 16'h0000);
      logged(16'h8000, 16'h0000);
    end
    rd(COUNT_PTR_OFFSET, {7'h7F, exp_ptr});
    rd(COUNT_PTR_OFFSET, {7'h00, exp_ptr});
    end_test("overrun");
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    check({15'h0, irq_n}, 16'h0001);
    rd(COUNT_PTR_OFFSET, 16'h0180);
    pulse(16'hE000, 16'h0000, 16'h0000, 16'h0000);
    rd(COUNT_PTR_OFFSET, 16'h0382);
    exp_ptr = 9'h180;
    logged(16'hE000, 16'h0000);
    end_test("second reset");
    finish_test();
  end
endmodule
`default_nettype wire
